// ### common/cpf_consts.vh
`ifndef CPF_CONSTS_VH
`define CPF_CONSTS_VH

// Clock and timing.
`define CPF_CLK_HZ        200000000
`define CPF_GATE_HZ       30
`define CPF_TMR_HZ        2000000
`define CPF_DUTY_STEPS    4096

// Output frequency limits and reset values.
`define CPF_FREQ_MIN      13'h0001
`define CPF_FREQ_MAX      13'h1388
`define CPF_FREQ_HIRES    13'h03e8
`define CPF_FREQ_RST      13'h0064
`define CPF_DUTY_RST      12'h000
`define CPF_DUTY_FULL     12'hfff
`define CPF_DUTY_10B_MASK 12'hffc

// Error codes.
`define CPF_CODE_OK       6'h00
`define CPF_CODE_STG      6'h01
`define CPF_CODE_STB      6'h02
`define CPF_CODE_OC       6'h04
`define CPF_CODE_OL       6'h10
`define CPF_CODE_GEN      6'h20

// Input modes.
`define CPF_MODE_DIG      3'h0
`define CPF_MODE_FREQ     3'h1
`define CPF_MODE_FDUTY    3'h2
`define CPF_MODE_VOLT     3'h3
`define CPF_MODE_CURR     3'h4
`define CPF_MODE_RES      3'h5

// Input termination.
`define CPF_PULL_FLOAT    2'h0
`define CPF_PULL_DOWN     2'h1
`define CPF_PULL_UP       2'h2

// Register map (byte addresses); outputs at 0x00/0x10, inputs at 0x40/0x50.
`define CPF_OUT_BASE      8'h00
`define CPF_IN_BASE       8'h40
`define CPF_CH_STRIDE     8'h10
`define CPF_OFS_A         8'h00
`define CPF_OFS_B         8'h04
`define CPF_OFS_C         8'h08
`define CPF_OFS_D         8'h0c

// Field positions.
`define CPF_CFG_MODE      2:0
`define CPF_CFG_PULL      5:4
`define CPF_CFG_RANGE     8
`define CPF_OCFG_PU       0

`endif

// ### src/cpf_ctrl.v
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "cpf_consts.vh"

module cpf_ctrl #(
   parameter GATE_CYC = `CPF_CLK_HZ / `CPF_GATE_HZ
) (
   // Clock and reset.
   input  wire        ref_clk,
   input  wire        rst_n,
   // Register port.
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Output driver diagnostics, one bit per output, asynchronous.
   input  wire [1:0]  drv_stg,
   input  wire [1:0]  drv_oc,
   input  wire [1:0]  drv_supply_sense,
   input  wire [1:0]  drv_open_sense,
   input  wire [1:0]  drv_overtemp,
   input  wire [1:0]  drv_generic,
   // Output driver controls.
   output reg  [1:0]  pwm_out,
   output reg  [1:0]  out_pullup_en,
   // Configurable input pins and front-end controls.
   input  wire [1:0]  in_pin,
   output reg  [1:0]  in_pullup_en,
   output reg  [1:0]  in_pulldown_en,
   output reg  [1:0]  in_shunt_en,
   output reg  [1:0]  in_high_range
);

   localparam TMR_DIV = `CPF_CLK_HZ / `CPF_TMR_HZ;
   // Accumulator wrap point, sized to the accumulator so the subtraction keeps its width.
   localparam [27:0] ACC_WRAP = `CPF_CLK_HZ;
   localparam NSYNC   = 14;

   // Pull termination applies only to the logic-level modes.
   function pull_allowed;
      input [2:0] mode;
      begin
         pull_allowed = (mode == `CPF_MODE_DIG) || (mode == `CPF_MODE_FREQ) || (mode == `CPF_MODE_FDUTY);
      end
   endfunction

   function [31:0] clamp_freq;
      input [31:0] w;
      begin
         if (w[12:0] < `CPF_FREQ_MIN || w[31:13] != 19'h0)
            clamp_freq = (w[31:13] != 19'h0) ? {19'h0, `CPF_FREQ_MAX} : {19'h0, `CPF_FREQ_MIN};
         else if (w[12:0] > `CPF_FREQ_MAX)
            clamp_freq = {19'h0, `CPF_FREQ_MAX};
         else
            clamp_freq = w;
      end
   endfunction

   // Three-stage synchronisers; a change counts once stages two and three agree.
   wire [NSYNC-1:0] raw = {in_pin, drv_generic, drv_overtemp, drv_open_sense,
                           drv_supply_sense, drv_oc, drv_stg};
   reg  [NSYNC-1:0] sy1;
   reg  [NSYNC-1:0] sy2;
   reg  [NSYNC-1:0] sy3;
   reg  [NSYNC-1:0] syf;

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         sy1 <= {NSYNC{1'b0}};
         sy2 <= {NSYNC{1'b0}};
         sy3 <= {NSYNC{1'b0}};
         syf <= {NSYNC{1'b0}};
      end else begin
         sy1 <= raw;
         sy2 <= sy1;
         sy3 <= sy2;
         syf <= (sy2 & sy3) | (syf & (sy2 | sy3));
      end
   end

   wire [1:0] f_stg  = syf[1:0];
   wire [1:0] f_oc   = syf[3:2];
   wire [1:0] f_stb  = syf[5:4];
   wire [1:0] f_ol   = syf[7:6];
   wire [1:0] f_otp  = syf[9:8];
   wire [1:0] f_gen  = syf[11:10];
   wire [1:0] f_in   = syf[13:12];

   // Shared measurement time bases: the gate interval and the 2 MHz tick.
   reg  [23:0] gate_cnt;
   reg         gate_end;
   reg  [7:0]  tmr_div;
   reg         tick_2m;

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         gate_cnt <= 24'h000000;
         gate_end <= 1'b0;
         tmr_div  <= 8'h00;
         tick_2m  <= 1'b0;
      end else begin
         gate_end <= 1'b0;
         tick_2m  <= 1'b0;
         if (gate_cnt == GATE_CYC - 1) begin
            gate_cnt <= 24'h000000;
            gate_end <= 1'b1;
         end else begin
            gate_cnt <= gate_cnt + 24'h000001;
         end
         if (tmr_div == TMR_DIV - 1) begin
            tmr_div <= 8'h00;
            tick_2m <= 1'b1;
         end else begin
            tmr_div <= tmr_div + 8'h01;
         end
      end
   end

   // Read words: index {addr[6], addr[4], addr[3:2]}.
   wire [511:0] rbus;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
         localparam [7:0] BASE = `CPF_OUT_BASE + gi * `CPF_CH_STRIDE;
         reg  [12:0] freq;
         reg  [11:0] duty;
         reg         pu_cfg;
         reg         en;
         reg         latched;
         reg  [5:0]  code;
         reg  [27:0] acc;
         reg  [11:0] pos;
         wire [27:0] acc_sum = acc + {3'h0, freq, 12'h000};
         wire [11:0] eff_duty = (freq > `CPF_FREQ_HIRES) ? (duty & `CPF_DUTY_10B_MASK) : duty;
         wire        level = (duty == `CPF_DUTY_FULL) || (pos < eff_duty);
         wire        wr_freq = reg_wr && (reg_addr == BASE + `CPF_OFS_A);
         wire        wr_duty = reg_wr && (reg_addr == BASE + `CPF_OFS_B);
         wire        wr_cfg  = reg_wr && (reg_addr == BASE + `CPF_OFS_C);
         wire        on_fault = en && (f_stg[gi] || f_oc[gi] || f_otp[gi] || f_gen[gi]);
         wire [31:0] fw = clamp_freq(reg_wdata);

         always @(posedge ref_clk) begin
            if (!rst_n) begin
               freq          <= `CPF_FREQ_RST;
               duty          <= `CPF_DUTY_RST;
               pu_cfg        <= 1'b1;
               en            <= 1'b0;
               latched       <= 1'b0;
               code          <= `CPF_CODE_OK;
               acc           <= 28'h0000000;
               pos           <= 12'h000;
               pwm_out[gi]   <= 1'b0;
               out_pullup_en[gi] <= 1'b0;
            end else begin
               if (wr_freq)
                  freq <= fw[12:0];
               if (wr_cfg)
                  pu_cfg <= reg_wdata[`CPF_OCFG_PU];
               // Phase accumulator steps the 4096-slot period at freq * 4096 slots per second.
               if (acc_sum >= ACC_WRAP) begin
                  acc <= acc_sum - ACC_WRAP;
                  pos <= pos + 12'h001;
               end else begin
                  acc <= acc_sum;
               end
               if (on_fault) begin
                  // The fault wins over a same-cycle duty write's enable and clear; the new duty value is still stored.
                  en      <= 1'b0;
                  latched <= 1'b1;
                  if (f_stg[gi] || f_otp[gi])
                     code <= `CPF_CODE_STG;
                  else if (f_oc[gi])
                     code <= `CPF_CODE_OC;
                  else
                     code <= `CPF_CODE_GEN;
                  if (wr_duty)
                     duty <= reg_wdata[11:0];
               end else if (wr_duty) begin
                  duty    <= reg_wdata[11:0];
                  latched <= 1'b0;
                  code    <= `CPF_CODE_OK;
                  en      <= (reg_wdata[11:0] != 12'h000) && !f_otp[gi];
               end else if (!en && !latched) begin
                  if (f_gen[gi])
                     code <= `CPF_CODE_GEN;
                  else if (pu_cfg)
                     code <= (f_ol[gi] || f_stb[gi]) ? `CPF_CODE_OL : `CPF_CODE_OK;
                  else
                     code <= f_stb[gi] ? `CPF_CODE_STB : `CPF_CODE_OK;
               end else if (en) begin
                  code <= `CPF_CODE_OK;
               end
               // Over-temperature forces the stage off even before the fault is latched.
               pwm_out[gi]       <= en && !f_otp[gi] && level && !on_fault;
               out_pullup_en[gi] <= pu_cfg && !en;
            end
         end

         assign rbus[(gi*4+0)*32 +: 32] = {19'h0, freq};
         assign rbus[(gi*4+1)*32 +: 32] = {20'h0, duty};
         assign rbus[(gi*4+2)*32 +: 32] = {31'h0, pu_cfg};
         assign rbus[(gi*4+3)*32 +: 32] = {22'h0, f_otp[gi], en, latched, 1'b0, code};
      end

      for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
         localparam [7:0] BASE = `CPF_IN_BASE + gi * `CPF_CH_STRIDE;
         reg  [2:0]  mode;
         reg  [1:0]  pull;
         reg         range;
         reg         prev;
         reg  [15:0] ecnt;
         reg  [23:0] first_t;
         reg  [23:0] last_t;
         reg  [15:0] res_cnt;
         reg  [23:0] res_span;
         reg  [15:0] tcnt;
         reg  [15:0] hi_cur;
         reg  [15:0] res_per;
         reg  [15:0] res_hi;
         wire        rise = f_in[gi] && !prev;
         wire        fall = !f_in[gi] && prev;
         wire        wr_cfg = reg_wr && (reg_addr == BASE + `CPF_OFS_A);

         always @(posedge ref_clk) begin
            if (!rst_n) begin
               mode     <= `CPF_MODE_DIG;
               pull     <= `CPF_PULL_FLOAT;
               range    <= 1'b0;
               prev     <= 1'b0;
               ecnt     <= 16'h0000;
               first_t  <= 24'h000000;
               last_t   <= 24'h000000;
               res_cnt  <= 16'h0000;
               res_span <= 24'h000000;
               tcnt     <= 16'h0000;
               hi_cur   <= 16'h0000;
               res_per  <= 16'h0000;
               res_hi   <= 16'h0000;
               in_pullup_en[gi]   <= 1'b0;
               in_pulldown_en[gi] <= 1'b0;
               in_shunt_en[gi]    <= 1'b0;
               in_high_range[gi]  <= 1'b0;
            end else begin
               if (wr_cfg) begin
                  mode  <= reg_wdata[`CPF_CFG_MODE];
                  pull  <= reg_wdata[`CPF_CFG_PULL];
                  range <= reg_wdata[`CPF_CFG_RANGE];
               end
               prev <= f_in[gi];
               // Pulse count and first/last edge times over one gate interval.
               if (gate_end) begin
                  res_cnt  <= ecnt;
                  res_span <= last_t - first_t;
                  ecnt     <= 16'h0000;
               end else if (rise && mode == `CPF_MODE_FREQ && ecnt != 16'hffff) begin
                  if (ecnt == 16'h0000)
                     first_t <= gate_cnt;
                  last_t <= gate_cnt;
                  ecnt   <= ecnt + 16'h0001;
               end
               // Period and high time in 2 MHz ticks; the counter saturates on a stuck input.
               if (mode != `CPF_MODE_FDUTY) begin
                  tcnt <= 16'h0000;
               end else if (rise) begin
                  res_per <= tcnt;
                  res_hi  <= hi_cur;
                  tcnt    <= 16'h0000;
               end else begin
                  if (fall)
                     hi_cur <= tcnt;
                  if (tick_2m && tcnt != 16'hffff)
                     tcnt <= tcnt + 16'h0001;
               end
               in_pullup_en[gi]   <= pull_allowed(mode) && pull == `CPF_PULL_UP;
               in_pulldown_en[gi] <= pull_allowed(mode) && pull == `CPF_PULL_DOWN;
               in_shunt_en[gi]    <= mode == `CPF_MODE_CURR;
               in_high_range[gi]  <= mode == `CPF_MODE_VOLT && range;
            end
         end

         assign rbus[(8+gi*4+0)*32 +: 32] = {23'h0, range, 2'h0, pull, 1'b0, mode};
         assign rbus[(8+gi*4+1)*32 +: 32] = {31'h0, f_in[gi]};
         assign rbus[(8+gi*4+2)*32 +: 32] = {res_span[15:0], res_cnt};
         assign rbus[(8+gi*4+3)*32 +: 32] = {res_hi, res_per};
      end
   endgenerate

   // Read data stands only in the cycle after the strobe; unmapped addresses read zero.
   wire       mapped = !reg_addr[7] && !reg_addr[5] && reg_addr[1:0] == 2'h0;
   wire [3:0] ridx   = {reg_addr[6], reg_addr[4], reg_addr[3:2]};

   always @(posedge ref_clk) begin
      if (!rst_n)
         reg_rdata <= 32'h00000000;
      else if (reg_rd && mapped)
         reg_rdata <= rbus[ridx*32 +: 32];
      else
         reg_rdata <= 32'h00000000;
   end

endmodule

// ### bench/cpf_load_model.sv
`timescale 1ns/1ps
module cpf_load_model (
   // Clock and design outputs
   input  wire        ref_clk,
   input  wire [1:0]  pwm_out,
   input  wire [1:0]  out_pullup_en,
   input  wire [1:0]  in_pullup_en,
   // Fault kind in bits 2:0, channel in bit 3; sensor high and low times
   input  wire [3:0]  flt,
   input  wire [15:0] hi_cyc,
   input  wire [15:0] lo_cyc,
   // Driver flags and input pins
   output wire [1:0]  drv_stg,
   output wire [1:0]  drv_oc,
   output wire [1:0]  drv_generic,
   output wire [1:0]  drv_overtemp,
   output wire [1:0]  drv_supply_sense,
   output wire [1:0]  drv_open_sense,
   output reg  [1:0]  in_pin = 2'b00
);
   wire [1:0] m = flt[3] ? 2'b10 : 2'b01;
   integer    n = 0;
   // A short or overload only shows while the switch conducts.
   assign drv_stg = (flt[2:0] == 3'h1) ? (m & pwm_out) : 2'b00;
   assign drv_oc = (flt[2:0] == 3'h2) ? (m & pwm_out) : 2'b00;
   assign drv_generic = (flt[2:0] == 3'h3) ? m : 2'b00;
   assign drv_overtemp = (flt[2:0] == 3'h4) ? m : 2'b00;
   assign drv_supply_sense = (flt[2:0] == 3'h5) ? (m & ~pwm_out) : 2'b00;
   // An open load is only seen through the diagnostic pull-up.
   assign drv_open_sense = (flt[2:0] == 3'h6) ? (m & ~pwm_out & out_pullup_en) : 2'b00;
   // With no sensor the pin floats to a weak low unless pulled up.
   always @(posedge ref_clk) begin
      n <= (n + 1 >= hi_cyc + lo_cyc) ? 0 : n + 1;
      in_pin <= (hi_cyc == 16'h0) ? in_pullup_en : {2{n < hi_cyc}};
   end
endmodule

// ### bench/cpf_ctrl_chk.sv
`timescale 1ns/1ps
module cpf_ctrl_chk (
   // Watched ports
   input wire        ref_clk,
   input wire        rst_n,
   input wire [7:0]  reg_addr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   input wire [1:0]  drv_stg,
   input wire [1:0]  drv_oc,
   input wire [1:0]  drv_overtemp,
   input wire [1:0]  drv_generic,
   input wire [1:0]  pwm_out,
   input wire [1:0]  out_pullup_en,
   input wire [1:0]  in_pullup_en,
   input wire [1:0]  in_pulldown_en,
   input wire [1:0]  in_shunt_en,
   input wire [1:0]  in_high_range
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire [1:0] hard = drv_stg | drv_oc | drv_overtemp | drv_generic;
   sequence held0; hard[0] [*8]; endsequence
   sequence held1; hard[1] [*8]; endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   unmapped_rd_a: assert property (reg_rd && reg_addr[7] |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   fault_off0_a: assert property (held0 |-> !pwm_out[0])
      else $error("output 0 on during fault");
   fault_off1_a: assert property (held1 |-> !pwm_out[1])
      else $error("output 1 on during fault");
   pullup_off_a: assert property ((pwm_out & $past(pwm_out) & out_pullup_en) == 2'b00)
      else $error("pull-up on while output on");
   pull_excl_a: assert property ((in_pullup_en & in_pulldown_en) == 2'b00)
      else $error("pull-up and pull-down together");
   shunt_alone_a: assert property ((in_shunt_en & (in_pullup_en | in_pulldown_en | in_high_range)) == 2'b00)
      else $error("shunt with other front-end");
   reset_off_a: assert property ($rose(rst_n) |-> pwm_out == 2'b00 && reg_rdata == 32'h0)
      else $error("outputs not idle after reset");
endmodule
bind cpf_ctrl cpf_ctrl_chk chk_u (.ref_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .drv_stg, .drv_oc,
   .drv_overtemp, .drv_generic, .pwm_out, .out_pullup_en, .in_pullup_en, .in_pulldown_en, .in_shunt_en,
   .in_high_range);

// ### bench/cpf_ctrl_tb.sv
`timescale 1ns/1ps
module cpf_ctrl_tb;
   reg         ref_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [7:0]  reg_addr = 8'h00;
   reg  [31:0] reg_wdata = 32'h0;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg  [3:0]  flt = 4'h0;
   reg  [15:0] hi_cyc = 16'h0;
   reg  [15:0] lo_cyc = 16'h0;
   wire [31:0] reg_rdata;
   wire [1:0]  drv_stg, drv_oc, drv_supply_sense, drv_open_sense, drv_overtemp, drv_generic;
   wire [1:0]  pwm_out, out_pullup_en, in_pin, in_pullup_en, in_pulldown_en, in_shunt_en, in_high_range;
   integer     fails = 0;
   integer     cmp_count = 0;
   integer     i, k, hi;
   reg  [31:0] q;
   cpf_ctrl #(.GATE_CYC(2000)) dut_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .drv_stg, .drv_oc, .drv_supply_sense, .drv_open_sense, .drv_overtemp, .drv_generic, .pwm_out,
      .out_pullup_en, .in_pin, .in_pullup_en, .in_pulldown_en, .in_shunt_en, .in_high_range);
   cpf_load_model ld_u (.ref_clk, .pwm_out, .out_pullup_en, .in_pullup_en, .flt, .hi_cyc, .lo_cyc, .drv_stg,
      .drv_oc, .drv_generic, .drv_overtemp, .drv_supply_sense, .drv_open_sense, .in_pin);
   initial forever #2.5 ref_clk = ~ref_clk;
   task give_verdict;
      begin
         $display("fails=%0d cmp_count=%0d", fails, cmp_count);
         if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge ref_clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] m, input [31:0] e);
      begin
         @(posedge ref_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1 q = reg_rdata;
         chk(q & m, e);
      end
   endtask
   // Counts cycles while output 0 holds level v; a stuck output ends the run.
   task span(input v);
      begin
         i = 0;
         while (pwm_out[0] === v && i < 50000) begin
            @(negedge ref_clk);
            i = i + 1;
         end
         if (i >= 50000) begin
            fails = fails + 1;
            give_verdict;
         end
      end
   endtask
   task off_case(input [3:0] f, input [31:0] pu, input [31:0] e);
      begin
         wr(8'h18, pu);
         @(posedge ref_clk);
         flt <= f;
         repeat (8) @(posedge ref_clk);
         rd(8'h1c, 32'h3f, e);
      end
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h1fff, 32'h64);
      rd(8'h08, 32'h1, 32'h1);
      wr(8'h20, 32'h5);
      rd(8'h20, 32'hffffffff, 32'h0);
      rd(8'h80, 32'hffffffff, 32'h0);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h1fff, 32'h1);
      wr(8'h00, 32'h1fff);
      rd(8'h00, 32'h1fff, 32'h1388);
      // Duty 6 above 1 kHz keeps only 4 steps of about 9.77 cycles each.
      wr(8'h04, 32'h6);
      // The first high phase starts mid-slot, so a full low and the high after it are timed.
      span(1'b1);
      span(1'b0);
      span(1'b1);
      span(1'b0);
      k = i;
      span(1'b1);
      hi = i;
      chk(hi >= 37 && hi <= 41, 1);
      chk(hi + k >= 39990 && hi + k <= 40010, 1);
      for (k = 1; k <= 4; k = k + 1) begin
         wr(8'h04, 32'hfff);
         repeat (4) @(negedge ref_clk);
         chk(pwm_out[0], 1'b1);
         @(posedge ref_clk);
         flt <= k;
         repeat (10) @(negedge ref_clk);
         chk(pwm_out[0], 1'b0);
         rd(8'h0c, 32'h3f, (k == 2) ? 32'h4 : (k == 3) ? 32'h20 : 32'h1);
         if (k == 4) begin
            wr(8'h04, 32'hfff);
            repeat (10) @(negedge ref_clk);
            chk(pwm_out[0], 1'b0);
            rd(8'h0c, 32'h1bf, 32'h0);
         end
         @(posedge ref_clk);
         flt <= 4'h0;
         repeat (8) @(posedge ref_clk);
         if (k != 4)
            rd(8'h0c, 32'h1bf, 32'h80 | ((k == 2) ? 32'h4 : (k == 3) ? 32'h20 : 32'h1));
         wr(8'h04, 32'h0);
         rd(8'h0c, 32'h1bf, 32'h0);
      end
      off_case(4'he, 32'h1, 32'h10);
      off_case(4'hd, 32'h1, 32'h10);
      off_case(4'hb, 32'h1, 32'h20);
      off_case(4'h0, 32'h1, 32'h0);
      off_case(4'hd, 32'h0, 32'h2);
      chk(out_pullup_en[1], 1'b0);
      off_case(4'he, 32'h0, 32'h0);
      for (k = 0; k < 6; k = k + 1) begin
         wr(8'h40, 32'h120 | k);
         repeat (2) @(negedge ref_clk);
         chk({in_pullup_en, in_pulldown_en[0], in_shunt_en[0], in_high_range[0]}, {1'b0, k <= 2, 1'b0, k == 4, k == 3});
      end
      wr(8'h50, 32'h4);
      repeat (2) @(negedge ref_clk);
      chk({in_shunt_en, in_high_range}, 4'h8);
      wr(8'h40, 32'h10);
      repeat (2) @(negedge ref_clk);
      chk(in_pulldown_en[0], 1'b1);
      rd(8'h44, 32'h1, 32'h0);
      wr(8'h40, 32'h20);
      repeat (8) @(posedge ref_clk);
      rd(8'h44, 32'h1, 32'h1);
      wr(8'h40, 32'h1);
      hi_cyc <= 16'd50;
      lo_cyc <= 16'd50;
      repeat (4100) @(posedge ref_clk);
      rd(8'h48, 32'hf800ffe0, 32'h0);
      chk(q[15:0] >= 19 && q[15:0] <= 21, 1);
      chk(q[31:16], (q[15:0] - 1) * 100);
      wr(8'h40, 32'h2);
      hi_cyc <= 16'd300;
      lo_cyc <= 16'd700;
      repeat (3000) @(posedge ref_clk);
      rd(8'h4c, 32'hfff0fff0, 32'h0);
      chk(q[15:0] >= 9 && q[15:0] <= 11, 1);
      chk(q[31:16] >= 2 && q[31:16] <= 4, 1);
      give_verdict;
   end
endmodule
